// File: src/dtc_pkg.sv
// Summary of operation
// - Two independent timers, each a 16-bit count of loadable low and high bytes.
// - Timer operation adds one per machine cycle, every 12 processor clocks.
// - Counter operation adds one per detected falling edge on its event input.
// - Recognising a falling edge takes two machine cycles, so half-rate counting at most.
// - Mode register: gate bits 7/3, select bits 6/2, mode pairs 5:4 and 1:0.
// - Select set counts external falling edges; select clear counts machine cycles.
// - Count only while run is set and gate is clear or gate input high.
// - Setting a run bit starts its timer.
// - Mode pair 00 13-bit, 01 16-bit, 10 8-bit reload, 11 split or hold.
// - Mode 0 counts high byte over low five bits; upper low bits undefined.
// - Rolling from all ones to zero sets the timer overflow flag.
// - Setting run never clears counts; counting resumes from held value.
// - Mode 1 matches mode 0 but uses all sixteen bits.
// - Mode 2 low byte counts; overflow sets flag and reloads from high byte.
// - Timer one in mode 3 holds its count as if stopped.
// - Timer zero mode 3 low byte uses timer zero select, gate, run, flag.
// - Timer zero mode 3 high byte counts cycles, runs on run one, sets flag one.
// - With timer zero split, timer one counts outside mode 3, serves baud ticks.
// - Control register: flag one bit 7, run one 6, flag zero 5, run zero 4.
package dtc_pkg;

  // ==========================================================================
  // Register addresses
  localparam logic [7:0] ADDR_CTRL = 8'h88;
  localparam logic [7:0] ADDR_MODE = 8'h89;
  localparam logic [7:0] ADDR_LO0  = 8'h8A;
  localparam logic [7:0] ADDR_LO1  = 8'h8B;
  localparam logic [7:0] ADDR_HI0  = 8'h8C;
  localparam logic [7:0] ADDR_HI1  = 8'h8D;

  // ==========================================================================
  // Field positions and reset values
  localparam int unsigned CTRL_OVF1 = 7;
  localparam int unsigned CTRL_RUN1 = 6;
  localparam int unsigned CTRL_OVF0 = 5;
  localparam int unsigned CTRL_RUN0 = 4;
  localparam int unsigned MODE_T1_LSB = 4;
  localparam int unsigned MODE_T0_LSB = 0;
  localparam logic [7:0] MODE_RST  = 8'h00;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;

  // ==========================================================================
  // Timing
  localparam int unsigned   MC_CLOCKS = 12;
  localparam logic [3:0]    MC_LAST   = 4'(MC_CLOCKS - 1);

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    DTC_M13,
    DTC_M16,
    DTC_M8R,
    DTC_SPLIT
  } dtc_tmode_t;

  typedef struct packed {
    logic       gate;
    logic       ext;
    dtc_tmode_t mode;
  } dtc_mode_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dtc_sfr_t;

endpackage

// File: src/dtc_pin_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_sampler (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Pin and machine cycle strobe
  input  wire logic pin,
  input  wire logic mc_tick,
  // Sampled results
  output logic      level,
  output logic      fall
);

  logic sync_a;
  logic sync_b;

  // ==========================================================================
  // Synchroniser
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
    end
  end

  // ==========================================================================
  // Once-per-machine-cycle sampling
  // A level shorter than one machine cycle may be missed entirely.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      level <= 1'b1;
      fall  <= 1'b0;
    end else begin
      fall <= mc_tick & level & ~sync_b;
      if (mc_tick) begin
        level <= sync_b;
      end
    end
  end

endmodule // dtc_pin_sampler
`default_nettype wire

// File: src/dtc_timer_core.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_core (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Special function register port
  input  wire dtc_pkg::dtc_sfr_t sfr,
  output logic [7:0]            sfr_rdata,
  // User port pins
  input  wire logic             event_input_zero,
  input  wire logic             event_input_one,
  input  wire logic             external_gate_input_zero,
  input  wire logic             external_gate_input_one,
  // Status
  output logic                  overflow_flag_zero,
  output logic                  overflow_flag_one,
  output logic                  baud_tick_one
);

  // ==========================================================================
  // Declarations
  logic [3:0]         presc;
  logic               mc_tick;
  logic [7:0]         timer_mode_select;
  logic               run_bit_zero;
  logic               run_bit_one;
  logic [7:0]         count_low_byte_zero;
  logic [7:0]         count_high_byte_zero;
  logic [7:0]         count_low_byte_one;
  logic [7:0]         count_high_byte_one;
  dtc_pkg::dtc_mode_t mode0;
  dtc_pkg::dtc_mode_t mode1;
  logic               split0;
  logic               gate_lvl0;
  logic               gate_lvl1;
  logic               fall0;
  logic               fall1;
  logic               inc0;
  logic               inc1;
  logic               inc0_hi;
  logic [16:0]        step0;
  logic [16:0]        step1;
  logic               ovf0_set;
  logic               ovf1_set;
  logic               t1_ovf;
  logic               wr_ctrl;
  logic               wr_mode;
  logic               wr_cnt0;
  logic               wr_cnt1;
  logic [15:0]        cnt0;
  logic [15:0]        cnt1;

  // ==========================================================================
  // One count step for either timer: {overflow, high, low}
  function automatic logic [16:0] count_step(input dtc_pkg::dtc_tmode_t m,
                                             input logic [15:0] c);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0]  s8;
    logic [16:0] r;
    s13 = {1'b0, c[15:8], c[4:0]} + 14'h0001;
    s16 = {1'b0, c} + 17'h0_0001;
    s8  = {1'b0, c[7:0]} + 9'h001;
    case (m)
      dtc_pkg::DTC_M13: begin
        // Bits 7:5 of the low byte are left as they were
        r = {s13[13], s13[12:5], c[7:5], s13[4:0]};
      end
      dtc_pkg::DTC_M16: begin
        r = s16;
      end
      dtc_pkg::DTC_M8R: begin
        r = {s8[8], c[15:8], (s8[8] ? c[15:8] : s8[7:0])};
      end
      dtc_pkg::DTC_SPLIT: begin
        r = {s8[8], c[15:8], s8[7:0]};
      end
      default: begin
        r = s16;
      end
    endcase
    return r;
  endfunction

  // ==========================================================================
  // Machine cycle prescaler
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      presc <= 4'h0;
    end else if (presc == dtc_pkg::MC_LAST) begin
      presc <= 4'h0;
    end else begin
      presc <= presc + 4'h1;
    end
  end

  assign mc_tick = (presc == dtc_pkg::MC_LAST);

  // ==========================================================================
  // Pin sampling
  dtc_pin_sampler u_event0 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin     (event_input_zero),
    .mc_tick (mc_tick),
    .level   (),
    .fall    (fall0)
  );

  dtc_pin_sampler u_event1 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin     (event_input_one),
    .mc_tick (mc_tick),
    .level   (),
    .fall    (fall1)
  );

  dtc_pin_sampler u_gate0 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin     (external_gate_input_zero),
    .mc_tick (mc_tick),
    .level   (gate_lvl0),
    .fall    ()
  );

  dtc_pin_sampler u_gate1 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin     (external_gate_input_one),
    .mc_tick (mc_tick),
    .level   (gate_lvl1),
    .fall    ()
  );

  // ==========================================================================
  // Decode
  assign wr_ctrl = sfr.wr && (sfr.addr == dtc_pkg::ADDR_CTRL);
  assign wr_mode = sfr.wr && (sfr.addr == dtc_pkg::ADDR_MODE);
  assign wr_cnt0 = sfr.wr && ((sfr.addr == dtc_pkg::ADDR_LO0) ||
                              (sfr.addr == dtc_pkg::ADDR_HI0));
  assign wr_cnt1 = sfr.wr && ((sfr.addr == dtc_pkg::ADDR_LO1) ||
                              (sfr.addr == dtc_pkg::ADDR_HI1));

  assign mode0  = dtc_pkg::dtc_mode_t'(timer_mode_select[dtc_pkg::MODE_T0_LSB +: 4]);
  assign mode1  = dtc_pkg::dtc_mode_t'(timer_mode_select[dtc_pkg::MODE_T1_LSB +: 4]);
  assign split0 = (mode0.mode == dtc_pkg::DTC_SPLIT);

  assign cnt0 = {count_high_byte_zero, count_low_byte_zero};
  assign cnt1 = {count_high_byte_one, count_low_byte_one};

  // ==========================================================================
  // Count enables
  // Timer zero low part behaves the same in every mode, split included
  assign inc0 = run_bit_zero && (!mode0.gate || gate_lvl0) &&
                (mode0.ext ? fall0 : mc_tick);
  // A timer one in mode 3 stops exactly as with run cleared
  assign inc1 = run_bit_one && (!mode1.gate || gate_lvl1) &&
                (mode1.mode != dtc_pkg::DTC_SPLIT) &&
                (mode1.ext ? fall1 : mc_tick);
  // Split high byte borrows run one and ignores gate and select
  assign inc0_hi = split0 && run_bit_one && mc_tick;

  assign step0 = count_step(mode0.mode, cnt0);
  assign step1 = count_step(mode1.mode, cnt1);

  assign ovf0_set = inc0 && step0[16];
  assign t1_ovf   = inc1 && step1[16];
  // Timer one loses its flag while timer zero is split
  assign ovf1_set = (t1_ovf && !split0) ||
                    (inc0_hi && (count_high_byte_zero == 8'hFF));

  // ==========================================================================
  // Mode register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timer_mode_select <= dtc_pkg::MODE_RST;
    end else if (wr_mode) begin
      timer_mode_select <= sfr.wdata;
    end
  end

  // ==========================================================================
  // Control register: run bits and overflow flags
  // A flag set by an overflow in the cycle of a clearing write survives.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_bit_zero       <= dtc_pkg::CTRL_RST[dtc_pkg::CTRL_RUN0];
      run_bit_one        <= dtc_pkg::CTRL_RST[dtc_pkg::CTRL_RUN1];
      overflow_flag_zero <= dtc_pkg::CTRL_RST[dtc_pkg::CTRL_OVF0];
      overflow_flag_one  <= dtc_pkg::CTRL_RST[dtc_pkg::CTRL_OVF1];
    end else if (wr_ctrl) begin
      run_bit_zero       <= sfr.wdata[dtc_pkg::CTRL_RUN0];
      run_bit_one        <= sfr.wdata[dtc_pkg::CTRL_RUN1];
      overflow_flag_zero <= sfr.wdata[dtc_pkg::CTRL_OVF0] | ovf0_set;
      overflow_flag_one  <= sfr.wdata[dtc_pkg::CTRL_OVF1] | ovf1_set;
    end else begin
      overflow_flag_zero <= overflow_flag_zero | ovf0_set;
      overflow_flag_one  <= overflow_flag_one | ovf1_set;
    end
  end

  // ==========================================================================
  // Timer zero counts; software writes win over a same-cycle increment
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_low_byte_zero  <= dtc_pkg::COUNT_RST;
      count_high_byte_zero <= dtc_pkg::COUNT_RST;
    end else begin
      if (inc0) begin
        count_low_byte_zero  <= step0[7:0];
        count_high_byte_zero <= step0[15:8];
      end
      if (inc0_hi) begin
        count_high_byte_zero <= count_high_byte_zero + 8'h01;
      end
      if (sfr.wr && (sfr.addr == dtc_pkg::ADDR_LO0)) begin
        count_low_byte_zero <= sfr.wdata;
      end
      if (sfr.wr && (sfr.addr == dtc_pkg::ADDR_HI0)) begin
        count_high_byte_zero <= sfr.wdata;
      end
    end
  end

  // ==========================================================================
  // Timer one counts
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_low_byte_one  <= dtc_pkg::COUNT_RST;
      count_high_byte_one <= dtc_pkg::COUNT_RST;
    end else begin
      if (inc1) begin
        count_low_byte_one  <= step1[7:0];
        count_high_byte_one <= step1[15:8];
      end
      if (sfr.wr && (sfr.addr == dtc_pkg::ADDR_LO1)) begin
        count_low_byte_one <= sfr.wdata;
      end
      if (sfr.wr && (sfr.addr == dtc_pkg::ADDR_HI1)) begin
        count_high_byte_one <= sfr.wdata;
      end
    end
  end

  // ==========================================================================
  // Baud tick keeps running while timer zero owns the flag
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      baud_tick_one <= 1'b0;
    end else begin
      baud_tick_one <= t1_ovf;
    end
  end

  // ==========================================================================
  // Read data, one cycle after the address
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else begin
      case (sfr.addr)
        dtc_pkg::ADDR_CTRL: sfr_rdata <= {overflow_flag_one, run_bit_one,
                                          overflow_flag_zero, run_bit_zero, 4'h0};
        dtc_pkg::ADDR_MODE: sfr_rdata <= timer_mode_select;
        dtc_pkg::ADDR_LO0:  sfr_rdata <= count_low_byte_zero;
        dtc_pkg::ADDR_HI0:  sfr_rdata <= count_high_byte_zero;
        dtc_pkg::ADDR_LO1:  sfr_rdata <= count_low_byte_one;
        dtc_pkg::ADDR_HI1:  sfr_rdata <= count_high_byte_one;
        default:            sfr_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Assertions
  mc_period_a: assert property (@(posedge ref_clk) disable iff (rst)
    mc_tick |-> ##12 mc_tick)
    else $error("machine cycle period is not 12 clocks");

  timer_step_a: assert property (@(posedge ref_clk) disable iff (rst)
    (inc0 && !mode0.ext && mode0.mode == dtc_pkg::DTC_M16 && !wr_cnt0)
      |=> cnt0 == $past(cnt0) + 16'h0001)
    else $error("timer zero did not advance by one");

  edge_count_a: assert property (@(posedge ref_clk) disable iff (rst)
    (fall0 && mode0.ext && run_bit_zero && !mode0.gate &&
     mode0.mode == dtc_pkg::DTC_M16 && !wr_cnt0)
      |=> cnt0 == $past(cnt0) + 16'h0001)
    else $error("falling edge not counted");

  gate_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    ((!run_bit_zero || (mode0.gate && !gate_lvl0)) && !wr_cnt0)
      |=> $stable(count_low_byte_zero))
    else $error("timer zero low byte moved while gated off");

  mode0_wrap_a: assert property (@(posedge ref_clk) disable iff (rst)
    (inc0 && mode0.mode == dtc_pkg::DTC_M13 && count_high_byte_zero == 8'hFF &&
     count_low_byte_zero[4:0] == 5'h1F && !wr_cnt0)
      |=> (count_high_byte_zero == 8'h00) && (count_low_byte_zero[4:0] == 5'h00) &&
          overflow_flag_zero)
    else $error("13-bit wrap wrong");

  reload_a: assert property (@(posedge ref_clk) disable iff (rst)
    (inc0 && mode0.mode == dtc_pkg::DTC_M8R && count_low_byte_zero == 8'hFF && !wr_cnt0)
      |=> (count_low_byte_zero == $past(count_high_byte_zero)) &&
          $stable(count_high_byte_zero) && overflow_flag_zero)
    else $error("auto reload wrong");

  t1_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    (mode1.mode == dtc_pkg::DTC_SPLIT && !wr_cnt1) |=> $stable(cnt1))
    else $error("timer one moved in mode 3");

  split_high_a: assert property (@(posedge ref_clk) disable iff (rst)
    (split0 && run_bit_one && mc_tick && count_high_byte_zero == 8'hFF && !wr_cnt0)
      |=> (count_high_byte_zero == 8'h00) && overflow_flag_one)
    else $error("split high byte overflow missed flag one");

  flag_wins_a: assert property (@(posedge ref_clk) disable iff (rst)
    ovf0_set |=> overflow_flag_zero)
    else $error("overflow flag zero lost");

  run_keeps_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_ctrl && sfr.wdata[dtc_pkg::CTRL_RUN0] && !run_bit_zero && !wr_cnt0 && !inc0_hi)
      |=> cnt0 == $past(cnt0))
    else $error("setting run changed the count");

  split_low_a: assert property (@(posedge ref_clk) disable iff (rst)
    (inc0 && split0 && count_low_byte_zero == 8'hFF && !wr_cnt0)
      |=> (count_low_byte_zero == 8'h00) && overflow_flag_zero)
    else $error("split low byte wrap wrong");

  split_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
    (split0 && !run_bit_one && !wr_cnt0) |=> $stable(count_high_byte_zero))
    else $error("split high byte moved without run one");

  baud_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
    t1_ovf |=> baud_tick_one)
    else $error("timer one overflow gave no baud tick");

endmodule // dtc_timer_core
`default_nettype wire

// File: tb/dtc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// External event source on one count pin
module dtc_pin_model (
  // Clock
  input  wire logic ref_clk,
  // Driven pin, idle high
  output var logic  pin
);
  initial pin = 1'b1;

  // Each level held a machine cycle or more, else it may be missed
  task automatic burst(input int k);
    for (int i = 0; i < k; i++) begin
      repeat ($urandom_range(12, 30)) @(posedge ref_clk);
      pin <= 1'b0;
      repeat ($urandom_range(12, 30)) @(posedge ref_clk);
      pin <= 1'b1;
    end
  endtask
endmodule // dtc_pin_model
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  // ============================================================
  // Signals
  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  dtc_pkg::dtc_sfr_t sfr = '0;
  logic [7:0]        sfr_rdata;
  logic              ev0, ev1, ovf0, ovf1, baud, seen0, seen1;
  logic              gate0 = 1'b1;
  logic              gate1 = 1'b1;
  logic [7:0]        rd_v, lo, hi, md, h8;
  logic [1:0]        m;
  int                err_count = 0;
  int                n_compared = 0;
  int                baud_cnt = 0;
  int                cycles = 0;
  int                ovf, b0, n, k;
  logic [7:0]        a3[4], ld3[4], ex3[4];

  dtc_timer_core u_dut (
    .ref_clk(ref_clk), .rst(rst), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .event_input_zero(ev0), .event_input_one(ev1),
    .external_gate_input_zero(gate0), .external_gate_input_one(gate1),
    .overflow_flag_zero(ovf0), .overflow_flag_one(ovf1), .baud_tick_one(baud));
  dtc_pin_model u_ev0 (.ref_clk(ref_clk), .pin(ev0));
  dtc_pin_model u_ev1 (.ref_clk(ref_clk), .pin(ev1));

  always #5 ref_clk = ~ref_clk;

  // Flags are sticky, but the stop write clears them, so latch them here
  always @(posedge ref_clk) begin
    cycles++;
    if (ovf0 === 1'b1) seen0 = 1'b1;
    if (ovf1 === 1'b1) seen1 = 1'b1;
    if (baud === 1'b1) baud_cnt++;
    if (cycles == 20000) begin
      err_count++;
      end_sim();
    end
  end

  // ============================================================
  // Bus and expectation helpers
  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk) sfr <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge ref_clk) sfr.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk) sfr <= '{wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge ref_clk) #1 rd_v = sfr_rdata;
  endtask

  function automatic void predict(input logic [1:0] mm, input int t, inout logic [7:0] l, h,
                                  output int o);
    logic [12:0] c;
    o = 0;
    for (int i = 0; i < t; i++) begin
      case (mm)
        2'd0: begin
          c = {h, l[4:0]} + 13'd1;
          if (c == 13'd0) o++;
          h = c[12:5];
          l = {l[7:5], c[4:0]};
        end
        2'd1: begin
          {h, l} = {h, l} + 16'd1;
          if ({h, l} == 16'd0) o++;
        end
        2'd2: if (l == 8'hFF) begin
          l = h;
          o++;
        end else l++;
        default: ;
      endcase
    end
  endfunction

  // Run for n machine cycles: exactly n ticks fall inside the window
  task automatic run_window(input logic [7:0] ctl, input int w);
    wr(dtc_pkg::ADDR_CTRL, ctl);
    #1 seen0 = 1'b0;
    seen1 = 1'b0;
    b0 = baud_cnt;
    repeat (12 * w - 2) @(posedge ref_clk);
    wr(dtc_pkg::ADDR_CTRL, 8'h00);
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic run_case(input bit t, input logic [7:0] mdv, l, h, input int w, tk);
    lo = l;
    hi = h;
    predict(t ? mdv[5:4] : mdv[1:0], tk, lo, hi, ovf);
    wr(dtc_pkg::ADDR_MODE, mdv);
    wr(t ? dtc_pkg::ADDR_LO1 : dtc_pkg::ADDR_LO0, l);
    wr(t ? dtc_pkg::ADDR_HI1 : dtc_pkg::ADDR_HI0, h);
    run_window(t ? 8'h40 : 8'h10, w);
    rd(t ? dtc_pkg::ADDR_LO1 : dtc_pkg::ADDR_LO0);
    `CHK(rd_v, lo)
    rd(t ? dtc_pkg::ADDR_HI1 : dtc_pkg::ADDR_HI0);
    `CHK(rd_v, hi)
    `CHK((t ? seen1 : seen0), (ovf != 0))
    if (t) `CHK(baud_cnt - b0, ovf)
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ============================================================
  // Scenarios
  initial begin
    void'($urandom(47073));
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(8'(dtc_pkg::ADDR_CTRL + i));
      `CHK(rd_v, 8'h00)
    end
    wr(8'h90, 8'($urandom));
    rd(8'h90);
    `CHK(rd_v, 8'h00)
    md = 8'($urandom);
    wr(dtc_pkg::ADDR_MODE, md);
    rd(dtc_pkg::ADDR_MODE);
    `CHK(rd_v, md)
    wr(dtc_pkg::ADDR_CTRL, 8'h5F);
    rd(dtc_pkg::ADDR_CTRL);
    `CHK(rd_v, 8'h50)
    wr(dtc_pkg::ADDR_CTRL, 8'h00);
    // Corners: single tick wraps, mode 0 keeps the top low bits
    run_case(0, 8'h01, 8'hFF, 8'hFF, 1, 1);
    run_case(1, 8'h00, 8'hBF, 8'hFF, 1, 1);
    for (int i = 0; i < 12; i++) begin
      m = 2'((i / 2) % 3);
      md = i[0] ? {2'b00, m, 4'h0} : {6'h00, m};
      n = $urandom_range(1, 30);
      h8 = (m == 2'd2) ? 8'($urandom_range(200, 255)) : 8'hFF;
      run_case(i[0], md, 8'($urandom) | 8'hE8, h8, n, n);
    end
    for (int g = 0; g < 4; g++) begin
      @(posedge ref_clk) gate0 <= g[1];
      gate1 <= g[1];
      repeat (36) @(posedge ref_clk);
      run_case(g[0], g[0] ? 8'h80 : 8'h08, 8'h10, 8'h00, 6, g[1] ? 6 : 0);
    end
    for (int t = 0; t < 2; t++) begin
      k = $urandom_range(3, 8);
      wr(dtc_pkg::ADDR_MODE, t ? 8'h50 : 8'h05);
      wr(t ? dtc_pkg::ADDR_LO1 : dtc_pkg::ADDR_LO0, 8'h00);
      wr(t ? dtc_pkg::ADDR_HI1 : dtc_pkg::ADDR_HI0, 8'h00);
      fork
        run_window(t ? 8'h40 : 8'h10, 5 * k + 4);
        if (t) u_ev1.burst(k);
        else u_ev0.burst(k);
      join
      rd(t ? dtc_pkg::ADDR_LO1 : dtc_pkg::ADDR_LO0);
      `CHK(rd_v, 8'(k))
    end
    // Timer zero split while timer one keeps counting in mode 1
    a3 = '{dtc_pkg::ADDR_LO0, dtc_pkg::ADDR_HI0, dtc_pkg::ADDR_LO1, dtc_pkg::ADDR_HI1};
    ld3 = '{8'hF0, 8'hFE, 8'hF8, 8'hFF};
    ex3 = '{8'h04, 8'h12, 8'h0C, 8'h00};
    wr(dtc_pkg::ADDR_MODE, 8'h13);
    for (int i = 0; i < 4; i++) wr(a3[i], ld3[i]);
    run_window(8'h50, 20);
    for (int i = 0; i < 4; i++) begin
      rd(a3[i]);
      `CHK(rd_v, ex3[i])
    end
    `CHK(seen0, 1'b1)
    `CHK(seen1, 1'b1)
    `CHK(baud_cnt - b0, 1)
    run_case(1, 8'h31, 8'($urandom), 8'($urandom), 10, 0);
    end_sim();
  end
endmodule // testbench
`default_nettype wire
